//--- src/gdp_gate_drive_ctrl.sv
// gate drive control and protection, top level with ahb-lite register slave
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`default_nettype none
module gdp_gate_drive_ctrl #(
   parameter int unsigned SETTLE_CYC = gdp_pkg::CLAMP_SETTLE_CYC
) (
   // clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   // ahb-lite slave
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic [31:0]                        hrdata,
   output logic                               hresp,
   // analog comparators
   input  wire logic                          ovp_warn_cmp,
   input  wire logic                          ovp_shut_cmp,
   input  wire logic                          oc_cmp_a,
   input  wire logic                          oc_cmp_b,
   // pwm path
   input  wire logic [2:0]                    pwm_hs_in,
   input  wire logic [2:0]                    pwm_ls_in,
   output logic [2:0]                         pwm_hs_out,
   output logic [2:0]                         pwm_ls_out,
   output logic [1:0]                         pwm_fault,
   // analog controls
   output logic                               clamp_enable_bit,
   output logic [gdp_pkg::TUNE_W-1:0]         clamp_tune,
   output logic                               hs_buf_en,
   output logic                               ls_buf_en,
   output logic [gdp_pkg::DS_W-1:0]           hs_strength,
   output logic [gdp_pkg::DS_W-1:0]           ls_strength,
   output logic                               low_side_pulldown_enable,
   output logic                               hs_pullup_en,
   output logic                               bias_source_select,
   output logic                               sense_amp_a_enable,
   output logic                               sense_amp_b_enable,
   output logic [gdp_pkg::THR_W-1:0]          dac_a,
   output logic [gdp_pkg::THR_W-1:0]          dac_b,
   // converter routing
   input  wire logic [2:0]                    adc_ch_sel,
   output logic                               route_supply,
   output logic                               route_amp_a,
   output logic                               route_amp_b,
   // interrupt
   output logic                               irq,
   output logic [3:0]                         irq_vector
);
   // =====================================================================
   // bus phase capture
   logic                              wr_pend_q, wr_pend_d;
   logic [7:0]                        wr_addr_q, wr_addr_d;
   logic [31:0]                       rdata_q, rdata_d;
   logic                              addr_ok;

   // only whole-word single transfers are used, so hsize is not decoded
   assign addr_ok = hsel & hready & htrans[1];

   always_comb begin
      wr_pend_d = addr_ok & hwrite;
      wr_addr_d = addr_ok ? haddr[7:0] : wr_addr_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rdata_q   <= 32'h0000_0000;
      end else begin
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q   <= rdata_d;
      end
   end

   // zero wait states: the read mux is sampled in the address phase
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_q;

   // =====================================================================
   // control registers
   logic                              clamp_en_q, clamp_en_d;
   logic [gdp_pkg::TUNE_W-1:0]        tune_q, tune_d;
   logic [gdp_pkg::IOCTL_W-1:0]       ioctl_q, ioctl_d;
   logic                              bias_q, bias_d;
   logic [1:0]                        amp_q, amp_d;
   logic [gdp_pkg::THR_W-1:0]         thr_a_q, thr_a_d, thr_b_q, thr_b_d;
   logic [gdp_pkg::FPR_W-1:0]         fpr_a_q, fpr_a_d, fpr_b_q, fpr_b_d;
   logic [gdp_pkg::IRQ_W-1:0]         mask_q, mask_d;

   function automatic logic hit(input logic [7:0] a);
      hit = wr_pend_q && (wr_addr_q == a);
   endfunction

   always_comb begin
      clamp_en_d = clamp_en_q;
      tune_d     = tune_q;
      ioctl_d    = ioctl_q;
      bias_d     = bias_q;
      amp_d      = amp_q;
      thr_a_d    = thr_a_q;
      thr_b_d    = thr_b_q;
      fpr_a_d    = fpr_a_q;
      fpr_b_d    = fpr_b_q;
      mask_d     = mask_q;
      if (hit(gdp_pkg::ADDR_CLAMP)) begin
         clamp_en_d = hwdata[gdp_pkg::CLAMP_EN_BIT];
         tune_d     = hwdata[gdp_pkg::TUNE_LSB +: gdp_pkg::TUNE_W];
      end
      if (hit(gdp_pkg::ADDR_IOCTL)) begin
         ioctl_d = hwdata[gdp_pkg::IOCTL_W-1:0];
      end
      if (hit(gdp_pkg::ADDR_BIAS)) begin
         bias_d = hwdata[0];
      end
      if (hit(gdp_pkg::ADDR_AMP)) begin
         amp_d = hwdata[1:0];
      end
      if (hit(gdp_pkg::ADDR_THR_A)) begin
         thr_a_d = hwdata[gdp_pkg::THR_W-1:0];
      end
      if (hit(gdp_pkg::ADDR_THR_B)) begin
         thr_b_d = hwdata[gdp_pkg::THR_W-1:0];
      end
      if (hit(gdp_pkg::ADDR_FPR_A)) begin
         fpr_a_d = hwdata[gdp_pkg::FPR_W-1:0];
      end
      if (hit(gdp_pkg::ADDR_FPR_B)) begin
         fpr_b_d = hwdata[gdp_pkg::FPR_W-1:0];
      end
      if (hit(gdp_pkg::ADDR_IRQ_MASK)) begin
         mask_d = hwdata[gdp_pkg::IRQ_W-1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clamp_en_q <= 1'b0;
         tune_q     <= gdp_pkg::RST_TUNE;
         ioctl_q    <= gdp_pkg::RST_IOCTL;
         bias_q     <= 1'b0;
         amp_q      <= 2'h0;
         thr_a_q    <= gdp_pkg::RST_THR;
         thr_b_q    <= gdp_pkg::RST_THR;
         fpr_a_q    <= gdp_pkg::RST_FPR;
         fpr_b_q    <= gdp_pkg::RST_FPR;
         mask_q     <= '0;
      end else begin
         clamp_en_q <= clamp_en_d;
         tune_q     <= tune_d;
         ioctl_q    <= ioctl_d;
         bias_q     <= bias_d;
         amp_q      <= amp_d;
         thr_a_q    <= thr_a_d;
         thr_b_q    <= thr_b_d;
         fpr_a_q    <= fpr_a_d;
         fpr_b_q    <= fpr_b_d;
         mask_q     <= mask_d;
      end
   end

   assign clamp_enable_bit         = clamp_en_q;
   assign clamp_tune               = tune_q;
   assign hs_buf_en                = ioctl_q[gdp_pkg::HS_BUF_BIT];
   assign ls_buf_en                = ioctl_q[gdp_pkg::LS_BUF_BIT];
   assign hs_strength              = ioctl_q[gdp_pkg::HS_DS_LSB +: gdp_pkg::DS_W];
   assign ls_strength              = ioctl_q[gdp_pkg::LS_DS_LSB +: gdp_pkg::DS_W];
   assign low_side_pulldown_enable = ioctl_q[gdp_pkg::PDE_BIT];
   assign hs_pullup_en             = 1'b1;
   assign bias_source_select       = bias_q;
   assign sense_amp_a_enable       = amp_q[0];
   assign sense_amp_b_enable       = amp_q[1];
   assign dac_a                    = thr_a_q;
   assign dac_b                    = thr_b_q;

   // =====================================================================
   // clamp settle indicator; software still owns the wait before hs enable
   logic [gdp_pkg::SETTLE_W-1:0]      settle_cnt_q, settle_cnt_d;
   logic                              settled_q, settled_d;

   always_comb begin
      settle_cnt_d = '0;
      settled_d    = 1'b0;
      if (clamp_en_q) begin
         settled_d    = settled_q | (settle_cnt_q == gdp_pkg::SETTLE_W'(SETTLE_CYC - 1));
         settle_cnt_d = settled_d ? settle_cnt_q : settle_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         settle_cnt_q <= '0;
         settled_q    <= 1'b0;
      end else begin
         settle_cnt_q <= settle_cnt_d;
         settled_q    <= settled_d;
      end
   end

   // =====================================================================
   // protection
   logic                              warn_q, shut_q, safe_q, warn_rise, shut_rise;
   logic                              oc_rise_a, oc_rise_b;
   logic [gdp_pkg::IRQ_W-1:0]         w1c;

   assign w1c = hit(gdp_pkg::ADDR_IRQ_STS) ? hwdata[gdp_pkg::IRQ_W-1:0] : '0;

   gdp_ovp_guard u_ovp (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .warn_cmp   (ovp_warn_cmp),
      .shut_cmp   (ovp_shut_cmp),
      .safe_clr   (w1c[gdp_pkg::IRQ_SHUT]),
      .pwm_hs_in  (pwm_hs_in),
      .pwm_ls_in  (pwm_ls_in),
      .pwm_hs_out (pwm_hs_out),
      .pwm_ls_out (pwm_ls_out),
      .warn_q     (warn_q),
      .shut_q     (shut_q),
      .safe_q     (safe_q),
      .warn_rise  (warn_rise),
      .shut_rise  (shut_rise)
   );

   gdp_limit_filter u_filt_a (
      .clk_sys (clk_sys),
      .rst     (rst),
      .cmp_in  (oc_cmp_a),
      .period  (fpr_a_q),
      .filt_q  (pwm_fault[0]),
      .rise    (oc_rise_a)
   );

   gdp_limit_filter u_filt_b (
      .clk_sys (clk_sys),
      .rst     (rst),
      .cmp_in  (oc_cmp_b),
      .period  (fpr_b_q),
      .filt_q  (pwm_fault[1]),
      .rise    (oc_rise_b)
   );

   // =====================================================================
   // interrupt status, set wins over a write-one clear
   logic [gdp_pkg::IRQ_W-1:0]         ists_q, ists_d;

   always_comb begin
      ists_d = (ists_q & ~w1c) | {oc_rise_b, oc_rise_a, shut_rise, warn_rise};
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ists_q <= '0;
      end else begin
         ists_q <= ists_d;
      end
   end

   assign irq        = |(ists_q & mask_q);
   assign irq_vector = gdp_pkg::OVP_IRQ_VECTOR;

   // =====================================================================
   // converter routing and read mux
   logic [2:0]                        route_q, route_d;

   always_comb begin
      route_d = {adc_ch_sel == gdp_pkg::ADC_CH_SUPPLY,
                 adc_ch_sel == gdp_pkg::ADC_CH_AMP_B,
                 adc_ch_sel == gdp_pkg::ADC_CH_AMP_A};
      rdata_d = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            gdp_pkg::ADDR_CLAMP:    rdata_d[4:0] = {tune_q, clamp_en_q};
            gdp_pkg::ADDR_IOCTL:    rdata_d[gdp_pkg::IOCTL_W-1:0] = ioctl_q;
            gdp_pkg::ADDR_STATUS:   rdata_d[5:0] = {pwm_fault, settled_q, safe_q, shut_q, warn_q};
            gdp_pkg::ADDR_IRQ_STS:  rdata_d[gdp_pkg::IRQ_W-1:0] = ists_q;
            gdp_pkg::ADDR_IRQ_MASK: rdata_d[gdp_pkg::IRQ_W-1:0] = mask_q;
            gdp_pkg::ADDR_BIAS:     rdata_d[0] = bias_q;
            gdp_pkg::ADDR_AMP:      rdata_d[1:0] = amp_q;
            gdp_pkg::ADDR_THR_A:    rdata_d[gdp_pkg::THR_W-1:0] = thr_a_q;
            gdp_pkg::ADDR_THR_B:    rdata_d[gdp_pkg::THR_W-1:0] = thr_b_q;
            gdp_pkg::ADDR_FPR_A:    rdata_d[gdp_pkg::FPR_W-1:0] = fpr_a_q;
            gdp_pkg::ADDR_FPR_B:    rdata_d[gdp_pkg::FPR_W-1:0] = fpr_b_q;
            default:                rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         route_q <= 3'h0;
      end else begin
         route_q <= route_d;
      end
   end

   assign route_amp_a  = route_q[0];
   assign route_amp_b  = route_q[1];
   assign route_supply = route_q[2];

   // =====================================================================
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   clamp_write_a: assert property (hit(gdp_pkg::ADDR_CLAMP) |=> clamp_enable_bit == $past(hwdata[0])
      && clamp_tune == $past(hwdata[4:1]))
      else $error("clamp control not taken from the write");
   io_write_a: assert property (hit(gdp_pkg::ADDR_IOCTL) |=> {low_side_pulldown_enable, ls_strength, hs_strength,
      ls_buf_en, hs_buf_en} == $past(hwdata[6:0]))
      else $error("driver control not taken from the write");
   status_read_a: assert property (addr_ok && !hwrite && haddr[7:0] == gdp_pkg::ADDR_STATUS
      |=> hrdata[1:0] == $past({shut_q, warn_q}))
      else $error("status read does not show supply flags");
   warn_irq_a: assert property (warn_rise && mask_q[gdp_pkg::IRQ_WARN] && !hit(gdp_pkg::ADDR_IRQ_MASK) |=> irq)
      else $error("warning did not raise the interrupt");
   supply_route_a: assert property (adc_ch_sel == gdp_pkg::ADC_CH_SUPPLY |=> route_supply && !route_amp_a
      && !route_amp_b)
      else $error("supply not routed to channel 7");
   amp_route_a: assert property (adc_ch_sel == gdp_pkg::ADC_CH_AMP_B |=> route_amp_b && !route_amp_a)
      else $error("amplifier b not routed to channel 6");
   dac_write_a: assert property (hit(gdp_pkg::ADDR_THR_B) |=> dac_b == $past(hwdata[5:0]) && $stable(dac_a))
      else $error("threshold b not applied to its dac");
   irq_raised_c: cover property (warn_rise ##[1:4] irq);
   clear_race_c: cover property (|(w1c & ists_d));
endmodule
`default_nettype wire

//--- src/gdp_pkg.sv
// constants shared by the gate drive protection control block
`default_nettype none
package gdp_pkg;
   // =====================================================================
   // clock and timing
   localparam int unsigned CLK_HZ            = 200_000_000;
   localparam int unsigned CLAMP_SETTLE_US   = 100;
   localparam int unsigned CLAMP_SETTLE_CYC  = CLAMP_SETTLE_US * (CLK_HZ / 1_000_000);
   localparam int unsigned SETTLE_W          = 15;

   // =====================================================================
   // register byte offsets
   localparam logic [7:0] ADDR_CLAMP         = 8'h00;
   localparam logic [7:0] ADDR_IOCTL         = 8'h04;
   localparam logic [7:0] ADDR_STATUS        = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STS       = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_MASK      = 8'h10;
   localparam logic [7:0] ADDR_BIAS          = 8'h14;
   localparam logic [7:0] ADDR_AMP           = 8'h18;
   localparam logic [7:0] ADDR_THR_A         = 8'h1c;
   localparam logic [7:0] ADDR_THR_B         = 8'h20;
   localparam logic [7:0] ADDR_FPR_A         = 8'h24;
   localparam logic [7:0] ADDR_FPR_B         = 8'h28;

   // =====================================================================
   // field positions and widths
   localparam int CLAMP_EN_BIT   = 0;
   localparam int TUNE_LSB       = 1;
   localparam int TUNE_W         = 4;
   localparam int HS_BUF_BIT     = 0;
   localparam int LS_BUF_BIT     = 1;
   localparam int HS_DS_LSB      = 2;
   localparam int LS_DS_LSB      = 4;
   localparam int DS_W           = 2;
   localparam int PDE_BIT        = 6;
   localparam int IOCTL_W        = 7;
   localparam int ST_WARN_BIT    = 0;
   localparam int ST_SHUT_BIT    = 1;
   localparam int ST_SAFE_BIT    = 2;
   localparam int ST_SETTLED_BIT = 3;
   localparam int ST_FAULT_LSB   = 4;
   localparam int IRQ_WARN       = 0;
   localparam int IRQ_SHUT       = 1;
   localparam int IRQ_OC_A       = 2;
   localparam int IRQ_OC_B       = 3;
   localparam int IRQ_W          = 4;
   localparam int THR_W          = 6;
   localparam int FPR_W          = 8;

   // =====================================================================
   // reset values and fixed numbers
   localparam logic [TUNE_W-1:0]  RST_TUNE       = 4'h0;
   localparam logic [IOCTL_W-1:0] RST_IOCTL      = 7'h00;
   localparam logic [THR_W-1:0]   RST_THR        = 6'h3f;
   localparam logic [FPR_W-1:0]   RST_FPR        = 8'h00;
   localparam logic [3:0]         OVP_IRQ_VECTOR = 4'h4;
   localparam logic [2:0]         ADC_CH_AMP_A   = 3'h5;
   localparam logic [2:0]         ADC_CH_AMP_B   = 3'h6;
   localparam logic [2:0]         ADC_CH_SUPPLY  = 3'h7;
endpackage
`default_nettype wire

//--- src/gdp_limit_filter.sv
// digital qualification filter for one over-current comparator
`default_nettype none
module gdp_limit_filter (
   // clock and reset
   input  wire logic                          clk_sys,
   input  wire logic                          rst,
   // comparator and setting
   input  wire logic                          cmp_in,
   input  wire logic [gdp_pkg::FPR_W-1:0]     period,
   // qualified result
   output logic                               filt_q,
   output logic                               rise
);
   // =====================================================================
   // state
   logic [gdp_pkg::FPR_W-1:0] cnt_q, cnt_d;
   logic                      filt_d;

   // a change is taken only after period+1 cycles of steady disagreement
   always_comb begin
      cnt_d  = '0;
      filt_d = filt_q;
      if (cmp_in != filt_q) begin
         if (cnt_q == period) begin
            filt_d = cmp_in;
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_q  <= '0;
         filt_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         filt_q <= filt_d;
      end
   end

   assign rise = filt_d & ~filt_q;

   // =====================================================================
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   filt_change_qual_a: assert property ($changed(filt_q) |-> $past(cmp_in) == filt_q && $past(cnt_q) == $past(period))
      else $error("filter output changed without qualification");
   glitch_block_a: assert property ((period != 8'h00 && cnt_q == 8'h00 && cmp_in != filt_q) ##1 (cmp_in == filt_q)
      |=> $stable(filt_q))
      else $error("single cycle glitch passed the filter");
   fault_taken_c: cover property ($rose(filt_q));
endmodule
`default_nettype wire

//--- src/gdp_ovp_guard.sv
// supply over-voltage flags, safety latch and pwm forcing
`default_nettype none
module gdp_ovp_guard (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // comparators and software clear
   input  wire logic        warn_cmp,
   input  wire logic        shut_cmp,
   input  wire logic        safe_clr,
   // pwm path
   input  wire logic [2:0]  pwm_hs_in,
   input  wire logic [2:0]  pwm_ls_in,
   output logic [2:0]       pwm_hs_out,
   output logic [2:0]       pwm_ls_out,
   // flags
   output logic             warn_q,
   output logic             shut_q,
   output logic             safe_q,
   output logic             warn_rise,
   output logic             shut_rise
);
   // =====================================================================
   // next state
   logic       safe_d;
   logic [2:0] hs_d, ls_d;

   always_comb begin
      // the live comparator sets the latch even in the cycle software clears it
      safe_d = shut_cmp | (safe_q & ~safe_clr);
      hs_d   = safe_d ? 3'h0 : pwm_hs_in;
      ls_d   = safe_d ? 3'h0 : pwm_ls_in;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         warn_q     <= 1'b0;
         shut_q     <= 1'b0;
         safe_q     <= 1'b0;
         pwm_hs_out <= 3'h0;
         pwm_ls_out <= 3'h0;
      end else begin
         warn_q     <= warn_cmp;
         shut_q     <= shut_cmp;
         safe_q     <= safe_d;
         pwm_hs_out <= hs_d;
         pwm_ls_out <= ls_d;
      end
   end

   assign warn_rise = warn_cmp & ~warn_q;
   assign shut_rise = shut_cmp & ~shut_q;

   // =====================================================================
   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);

   safe_force_a: assert property (shut_cmp |=> safe_q && pwm_hs_out == 3'h0 && pwm_ls_out == 3'h0)
      else $error("pwm not forced inactive on shutdown");
   safe_hold_a: assert property (safe_q && !safe_clr |=> safe_q)
      else $error("safety state left without a clear");
   safe_entry_c: cover property ($rose(safe_q));
endmodule
`default_nettype wire

//--- verification/gdp_bridge_model.sv
// far side model: supply and shunt comparators seen by the gate drive block
`default_nettype none
module gdp_bridge_model (
   // levels set by the bench
   input  wire logic [4:0]                supply_v,
   input  wire logic [5:0]                shunt_a,
   input  wire logic [5:0]                shunt_b,
   // block controls
   input  wire logic [gdp_pkg::THR_W-1:0] dac_a,
   input  wire logic [gdp_pkg::THR_W-1:0] dac_b,
   input  wire logic                      amp_a_en,
   input  wire logic                      amp_b_en,
   // comparator outputs
   output logic                           warn_cmp,
   output logic                           shut_cmp,
   output logic                           cmp_a,
   output logic                           cmp_b
);
   timeunit 1ns;
   timeprecision 100ps;
   assign warn_cmp = supply_v > 5'd22;
   assign shut_cmp = supply_v > 5'd24;
   // disabled amplifier gives no signal, so no trip
   assign cmp_a = amp_a_en && (shunt_a > dac_a);
   assign cmp_b = amp_b_en && (shunt_b > dac_b);
endmodule
`default_nettype wire

//--- verification/tb_gdp_gate_drive_ctrl.sv
// bench for the gate drive protection control block
`default_nettype none
module tb_gdp_gate_drive_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, ow, os, oa, ob, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans, pwm_fault;
   logic [2:0] hsize, pwm_hs_in, pwm_ls_in, pwm_hs_out, pwm_ls_out, adc_ch_sel;
   logic ce, hb, lb, pd, pu, bs, ea, eb, rs, ra, rb;
   logic [3:0] tune, irq_vector;
   logic [1:0] hds, lds;
   logic [5:0] dac_a, dac_b, shunt_a, shunt_b;
   logic [4:0] supply_v;
   int fail_count, check_count;
   assign hready = hreadyout;
   // full settle time kept so the bench honours the real clamp wait
   gdp_gate_drive_ctrl u_gdp_gate_drive_ctrl (.clk_sys(clk_sys), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ovp_warn_cmp(ow), .ovp_shut_cmp(os),
      .oc_cmp_a(oa), .oc_cmp_b(ob), .pwm_hs_in(pwm_hs_in), .pwm_ls_in(pwm_ls_in), .pwm_hs_out(pwm_hs_out),
      .pwm_ls_out(pwm_ls_out), .pwm_fault(pwm_fault), .clamp_enable_bit(ce), .clamp_tune(tune),
      .hs_buf_en(hb), .ls_buf_en(lb), .hs_strength(hds), .ls_strength(lds), .low_side_pulldown_enable(pd),
      .hs_pullup_en(pu), .bias_source_select(bs), .sense_amp_a_enable(ea), .sense_amp_b_enable(eb),
      .dac_a(dac_a), .dac_b(dac_b), .adc_ch_sel(adc_ch_sel), .route_supply(rs), .route_amp_a(ra),
      .route_amp_b(rb), .irq(irq), .irq_vector(irq_vector));
   gdp_bridge_model u_gdp_bridge_model (.supply_v(supply_v), .shunt_a(shunt_a), .shunt_b(shunt_b),
      .dac_a(dac_a), .dac_b(dac_b), .amp_a_en(ea), .amp_b_en(eb), .warn_cmp(ow), .shut_cmp(os),
      .cmp_a(oa), .cmp_b(ob));
   // =====================================================================
   // tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // hold each phase until hready is sampled high, bounded
   task automatic wait_rdy();
      int n;
      n = 0;
      @(posedge clk_sys);
      while (hready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n >= 50) begin
         fail_count++;
         complete_run();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] d;
      bus(a, 1'b0, 32'h0, d);
      chk(d, exp, what);
   endtask
   // =====================================================================
   // sequence
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      fail_count++;
      complete_run();
   end
   initial begin
      {rst, hsel, hwrite, haddr, hwdata, htrans, hsize} = {1'b1, 1'b1, 1'b0, 32'h0, 32'h0, 2'b00, 3'h2};
      {pwm_hs_in, pwm_ls_in, adc_ch_sel, supply_v, shunt_a, shunt_b} = '0;
      fail_count = 0;
      check_count = 0;
      step(10);
      rst <= 1'b0;
      step(1);
      rd_chk(gdp_pkg::ADDR_THR_A, 32'h3f, "thr reset");
      rd_chk(8'h40, 32'h0, "unmapped");
      chk({hresp, hreadyout, pu, irq_vector, irq}, 8'h68, "fixed outs");
      $display("test reset done");
      wr(gdp_pkg::ADDR_CLAMP, 32'h1b);
      step(1);
      chk({ce, tune}, 5'h1d, "clamp");
      rd_chk(gdp_pkg::ADDR_STATUS, 32'h0, "not settled");
      // high-side buffers only after the full clamp wait
      step(gdp_pkg::CLAMP_SETTLE_CYC);
      rd_chk(gdp_pkg::ADDR_STATUS, 32'h8, "settled");
      wr(gdp_pkg::ADDR_IOCTL, 32'h7b);
      step(1);
      chk({pd, lds, hds, lb, hb}, 7'h7b, "io ctl");
      wr(gdp_pkg::ADDR_BIAS, 32'h1);
      wr(gdp_pkg::ADDR_AMP, 32'h2);
      step(1);
      chk({bs, eb, ea}, 3'h6, "bias amp");
      wr(gdp_pkg::ADDR_AMP, 32'h3);
      $display("test config done");
      for (int c = 4; c < 8; c++) begin
         adc_ch_sel <= 3'(c);
         step(2);
         chk({rs, rb, ra}, {c == 7, c == 6, c == 5}, "route");
      end
      pwm_hs_in <= 3'h5;
      pwm_ls_in <= 3'h2;
      supply_v <= 5'd23;
      wr(gdp_pkg::ADDR_IRQ_MASK, 32'h0);
      chk(irq, 1'b0, "masked");
      wr(gdp_pkg::ADDR_IRQ_MASK, 32'hf);
      step(1);
      chk({irq, pwm_hs_out, pwm_ls_out}, 7'h6a, "warn");
      rd_chk(gdp_pkg::ADDR_STATUS, 32'h9, "warn flag");
      supply_v <= 5'd25;
      step(2);
      chk({pwm_hs_out, pwm_ls_out}, 6'h0, "safe");
      rd_chk(gdp_pkg::ADDR_IRQ_STS, 32'h3, "ov events");
      supply_v <= 5'd20;
      wr(gdp_pkg::ADDR_IRQ_STS, 32'h3);
      step(2);
      chk({irq, pwm_hs_out, pwm_ls_out}, 7'h2a, "release");
      $display("test overvoltage done");
      wr(gdp_pkg::ADDR_THR_A, 32'h10);
      wr(gdp_pkg::ADDR_FPR_A, 32'h3);
      wr(gdp_pkg::ADDR_THR_B, 32'h1);
      shunt_a <= 6'h10;
      shunt_b <= 6'h2;
      step(8);
      chk({dac_a, pwm_fault}, 8'h42, "at level");
      shunt_a <= 6'h11;
      step(2);
      shunt_a <= 6'h0;
      step(6);
      chk(pwm_fault, 2'b10, "glitch");
      shunt_a <= 6'h11;
      step(8);
      chk(pwm_fault, 2'b11, "trip");
      rd_chk(gdp_pkg::ADDR_IRQ_STS, 32'hc, "oc events");
      $display("test overcurrent done");
      // pre-drivers off before the chip would enter stop mode
      wr(gdp_pkg::ADDR_IOCTL, 32'h0);
      step(1);
      chk({pd, lds, hds, lb, hb}, 7'h00, "drivers off");
      $display("test stop prep done");
      complete_run();
   end
endmodule
`default_nettype wire
